/* hdl/rsf_pkg.sv */
// Package: constants and types for the RTU serial frame engine (master side)
`default_nettype none
package rsf_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 100_000_000;
	localparam int BAUD_DEFAULT = 9600;
	// Bit time in clock cycles at the default rate
	localparam int BIT_CYC_DEFAULT = CLK_HZ / BAUD_DEFAULT;
	// Silence thresholds in tenths of a character time
	localparam int SIL_END_TENTHS = 35;
	localparam int GAP_MAX_TENTHS = 15;
	localparam int CHAR_BITS_MAX = 11;
	// ----------------------------------------------------------------
	// Frame constants
	// ----------------------------------------------------------------
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam logic [7:0] ADDR_BCAST = 8'h00;
	localparam logic [7:0] ADDR_MAX = 8'hf7;
	localparam logic [7:0] CMD_READ = 8'h03;
	localparam logic [7:0] CMD_WRITE = 8'h06;
	localparam int RX_MAX_BYTES = 64;
	// ----------------------------------------------------------------
	// Parity modes
	// ----------------------------------------------------------------
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_EVEN = 2'h1;
	localparam logic [1:0] PAR_ODD = 2'h2;
	// Serial engine states
	typedef enum logic [4:0] {
		RSF_IDLE = 5'b00001,
		RSF_START = 5'b00010,
		RSF_DATA = 5'b00100,
		RSF_PAR = 5'b01000,
		RSF_STOP = 5'b10000
	} rsf_ser_e;
endpackage
`default_nettype wire

/* hdl/rsf_crc.sv */
// One-byte CRC-16 update step for the frame engine
`default_nettype none
module rsf_crc
	import rsf_pkg::*;
(
	input wire logic [15:0] crc_in,
	input wire logic [7:0] data,
	output logic [15:0] crc_out
);
	// ----------------------------------------------------------------
	// Eight shift steps unrolled by a loop
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [15:0] c;
		c = crc_in ^ {8'h00, data};
		for (int i = 0; i < 8; i++)
		begin
			if (c[0])
				c = (c >> 1) ^ CRC_POLY;
			else
				c = c >> 1;
		end
		crc_out = c;
	end
endmodule
`default_nettype wire

/* hdl/rsf_master.sv */
// RTU master: frames, sends and checks serial messages to the slave
// Functional notes
// - Start bit then 7 or 8 data bits, LSB first.
// - One parity bit when parity selected, none otherwise.
// - One stop bit with parity, two stop bits without.
// - Even parity: bit is 1 when data has odd ones count.
// - Odd parity: bit is 0 when data has odd ones count.
// - Start a frame only after 3.5 character times idle.
// - Send address, command, data bytes, then two CRC bytes.
// - Bytes back to back; gap over 1.5 chars discards partial frame.
// - Inter-frame silence under 3.5 chars appends; keep full silence.
// - Address 0 to 247, zero means broadcast.
// - Command 03H reads, 06H writes.
// - Data field holds 2*N bytes forming N words.
// - CRC sent low byte first, then high byte.
// - CRC starts at 0xffff for each frame.
// - Only the 8 data bits enter the CRC.
// - XOR byte in, eight shifts with 0xa001 on carry.
// - Network gives all nodes same settings and unique addresses.
// - Multi-byte fields sent high byte first.
// - Half-duplex RS485 link, RTU mode only.
`default_nettype none
module rsf_master
	import rsf_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	// Configuration, held stable while busy
	input wire logic [15:0] bit_cyc,
	input wire logic [1:0] par_mode,
	input wire logic data7,
	// Transmit byte stream; tx_last marks the final payload byte
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	input wire logic tx_valid,
	output logic tx_ready,
	// Received bytes, CRC bytes included
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic rx_end,
	output logic rx_crc_ok,
	output logic rx_par_err,
	output logic busy,
	// RS485 pins
	input wire logic line_rx,
	output logic line_tx,
	output logic line_oe
);
	// ----------------------------------------------------------------
	// Character timing
	// ----------------------------------------------------------------
	// Character length: start, data, parity or second stop, stop
	logic [3:0] char_bits;
	logic [31:0] char_cyc;
	logic [31:0] sil_cyc;
	logic [31:0] gap_cyc;
	assign char_bits = data7 ? 4'd10 : 4'd11;
	assign char_cyc = 32'(bit_cyc) * 32'(char_bits);
	assign sil_cyc = (char_cyc * 32'(SIL_END_TENTHS) + 32'd9) / 32'd10;
	assign gap_cyc = (char_cyc * 32'(GAP_MAX_TENTHS)) / 32'd10;
	// ----------------------------------------------------------------
	// Input synchroniser
	// ----------------------------------------------------------------
	logic rx_s1_r;
	logic rx_s2_r;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rx_s1_r <= 1'b1;
			rx_s2_r <= 1'b1;
		end
		else
		begin
			rx_s1_r <= line_rx;
			rx_s2_r <= rx_s1_r;
		end
	end
	// ----------------------------------------------------------------
	// Transmitter
	// ----------------------------------------------------------------
	rsf_ser_e ts_r, ts_nxt;
	logic [15:0] tb_r, tb_nxt;
	logic [3:0] tn_r, tn_nxt;
	logic [7:0] tsh_r, tsh_nxt;
	logic tp_r, tp_nxt;
	logic [1:0] tcrc_r, tcrc_nxt; // 0 payload, 1 low, 2 high
	logic tlast_r, tlast_nxt;
	logic [15:0] tc_r, tc_nxt;
	logic [31:0] idle_r, idle_nxt;
	logic tx_r, tx_nxt;
	logic oe_r, oe_nxt;
	logic [15:0] tcrc_upd;
	logic line_busy;
	rsf_crc u_tcrc (
		.crc_in(tc_r),
		.data(tsh_r),
		.crc_out(tcrc_upd)
	);
	// Transmitter may only begin once the line has been quiet long enough
	assign tx_ready = (ts_r == RSF_IDLE) && (tcrc_r == 2'd0) && !tlast_r
		&& (oe_r || idle_r >= sil_cyc);
	// Next-state for the character shifter and framer
	always_comb
	begin
		ts_nxt = ts_r;
		tb_nxt = tb_r;
		tn_nxt = tn_r;
		tsh_nxt = tsh_r;
		tp_nxt = tp_r;
		tcrc_nxt = tcrc_r;
		tlast_nxt = tlast_r;
		tc_nxt = tc_r;
		tx_nxt = tx_r;
		oe_nxt = oe_r;
		idle_nxt = (line_busy || oe_r) ? 32'd0 : (idle_r == 32'hffffffff ? idle_r : idle_r + 32'd1);
		case (ts_r)
			RSF_IDLE:
			begin
				if (tx_valid && tx_ready)
				begin
					tsh_nxt = tx_data;
					tlast_nxt = tx_last;
					if (!oe_r)
						tc_nxt = CRC_INIT;
					ts_nxt = RSF_START;
					oe_nxt = 1'b1;
					tx_nxt = 1'b0;
					tb_nxt = '0;
				end
				else if (tcrc_r != 2'd0)
				begin
					// CRC bytes follow the payload with no gap
					tsh_nxt = (tcrc_r == 2'd1) ? tc_r[7:0] : tc_r[15:8];
					ts_nxt = RSF_START;
					tx_nxt = 1'b0;
					tb_nxt = '0;
				end
				else if (tlast_r)
				begin
					tlast_nxt = 1'b0;
					tcrc_nxt = 2'd1;
				end
				else if (oe_r)
					oe_nxt = 1'b0; // Release bus after the last stop bit
			end
			RSF_START:
			begin
				tb_nxt = tb_r + 16'd1;
				if (tb_r + 16'd1 >= bit_cyc)
				begin
					tb_nxt = '0;
					tn_nxt = '0;
					ts_nxt = RSF_DATA;
					tx_nxt = tsh_r[0];
					tp_nxt = ^(data7 ? {1'b0, tsh_r[6:0]} : tsh_r);
					if (tcrc_r == 2'd0)
						tc_nxt = tcrc_upd;
				end
			end
			RSF_DATA:
			begin
				tb_nxt = tb_r + 16'd1;
				if (tb_r + 16'd1 >= bit_cyc)
				begin
					tb_nxt = '0;
					tn_nxt = tn_r + 4'd1;
					if (tn_r == (data7 ? 4'd6 : 4'd7))
					begin
						if (par_mode != PAR_NONE)
						begin
							ts_nxt = RSF_PAR;
							tx_nxt = (par_mode == PAR_EVEN) ? tp_r : !tp_r;
						end
						else
						begin
							ts_nxt = RSF_STOP;
							tx_nxt = 1'b1;
							tn_nxt = 4'd0;
						end
					end
					else
						tx_nxt = tsh_r[tn_r[2:0] + 3'd1];
				end
			end
			RSF_PAR:
			begin
				tb_nxt = tb_r + 16'd1;
				if (tb_r + 16'd1 >= bit_cyc)
				begin
					tb_nxt = '0;
					tn_nxt = 4'd1; // Only one stop bit remains
					ts_nxt = RSF_STOP;
					tx_nxt = 1'b1;
				end
			end
			RSF_STOP:
			begin
				tb_nxt = tb_r + 16'd1;
				if (tb_r + 16'd1 >= bit_cyc)
				begin
					tb_nxt = '0;
					tn_nxt = tn_r + 4'd1;
					if (tn_r == 4'd1)
					begin
						ts_nxt = RSF_IDLE;
						if (tcrc_r == 2'd1)
							tcrc_nxt = 2'd2;
						else if (tcrc_r == 2'd2)
						begin
							// Release with the last stop bit, so no byte slips in before silence
							tcrc_nxt = 2'd0;
							oe_nxt = 1'b0;
						end
					end
				end
			end
			default:
				ts_nxt = RSF_IDLE;
		endcase
	end
	// Transmit registers
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ts_r <= RSF_IDLE;
			tb_r <= '0;
			tn_r <= '0;
			tsh_r <= '0;
			tp_r <= 1'b0;
			tcrc_r <= 2'd0;
			tlast_r <= 1'b0;
			tc_r <= CRC_INIT;
			idle_r <= '0;
			tx_r <= 1'b1;
			oe_r <= 1'b0;
		end
		else
		begin
			ts_r <= ts_nxt;
			tb_r <= tb_nxt;
			tn_r <= tn_nxt;
			tsh_r <= tsh_nxt;
			tp_r <= tp_nxt;
			tcrc_r <= tcrc_nxt;
			tlast_r <= tlast_nxt;
			tc_r <= tc_nxt;
			idle_r <= idle_nxt;
			tx_r <= tx_nxt;
			oe_r <= oe_nxt;
		end
	end
	assign line_tx = tx_r;
	assign line_oe = oe_r;
	// ----------------------------------------------------------------
	// Receiver (response path)
	// ----------------------------------------------------------------
	rsf_ser_e rs_r, rs_nxt;
	logic [15:0] rb_r, rb_nxt;
	logic [3:0] rn_r, rn_nxt;
	logic [7:0] rsh_r, rsh_nxt;
	logic [15:0] rc_r, rc_nxt;
	logic [15:0] rcp_r, rcp_nxt; // CRC before the last byte
	logic [15:0] rcq_r, rcq_nxt;
	logic [7:0] rlo_r, rlo_nxt;
	logic [7:0] rhi_r, rhi_nxt;
	logic [1:0] rf_r, rf_nxt; // 0 idle, 1 in frame
	logic [31:0] rq_r, rq_nxt;
	logic rperr_r, rperr_nxt;
	logic end_r, end_nxt;
	logic crcok_r, crcok_nxt;
	logic [7:0] rbyte;
	logic rbyte_v;
	logic [15:0] rcrc_upd;
	logic buf_ready;
	rsf_crc u_rcrc (
		.crc_in(rc_r),
		.data(rbyte),
		.crc_out(rcrc_upd)
	);
	// Line counts as busy while a response character is on the pair
	assign line_busy = !rx_s2_r || (rs_r != RSF_IDLE);
	assign busy = oe_r || (rf_r != 2'd0);
	// Receiver next state; silence counted only while no character arrives
	always_comb
	begin
		rs_nxt = rs_r;
		rb_nxt = rb_r;
		rn_nxt = rn_r;
		rsh_nxt = rsh_r;
		rc_nxt = rc_r;
		rcp_nxt = rcp_r;
		rcq_nxt = rcq_r;
		rlo_nxt = rlo_r;
		rhi_nxt = rhi_r;
		rf_nxt = rf_r;
		rperr_nxt = rperr_r;
		end_nxt = 1'b0;
		crcok_nxt = crcok_r;
		rbyte = data7 ? {1'b0, rsh_r[7:1]} : rsh_r;
		rbyte_v = 1'b0;
		rq_nxt = (rs_r == RSF_IDLE && rq_r != 32'hffffffff) ? rq_r + 32'd1 : 32'd0;
		if (rf_r != 2'd0 && rs_r == RSF_IDLE && rq_r == sil_cyc)
		begin
			rf_nxt = 2'd0; // Response ends after full silence
			end_nxt = 1'b1;
			crcok_nxt = (rcq_r == {rhi_r, rlo_r});
		end
		case (rs_r)
			RSF_IDLE:
			begin
				if (!rx_s2_r && !oe_r)
				begin
					rs_nxt = RSF_START;
					rb_nxt = '0;
					// A long gap inside a response drops the partial frame and restarts
					if (rf_r == 2'd0 || rq_r > gap_cyc)
					begin
						rc_nxt = CRC_INIT;
						rperr_nxt = 1'b0;
						rf_nxt = 2'd1;
					end
				end
			end
			RSF_START:
			begin
				rb_nxt = rb_r + 16'd1;
				if (rb_r + 16'd1 >= (bit_cyc >> 1))
				begin
					rb_nxt = '0;
					rn_nxt = '0;
					rs_nxt = rx_s2_r ? RSF_IDLE : RSF_DATA; // Reject glitches
				end
			end
			RSF_DATA:
			begin
				rb_nxt = rb_r + 16'd1;
				if (rb_r + 16'd1 >= bit_cyc)
				begin
					rb_nxt = '0;
					rsh_nxt = {rx_s2_r, rsh_r[7:1]};
					rn_nxt = rn_r + 4'd1;
					if (rn_r == (data7 ? 4'd6 : 4'd7))
						rs_nxt = (par_mode != PAR_NONE) ? RSF_PAR : RSF_STOP;
				end
			end
			RSF_PAR:
			begin
				rb_nxt = rb_r + 16'd1;
				if (rb_r + 16'd1 >= bit_cyc)
				begin
					rb_nxt = '0;
					if ((^rbyte ^ rx_s2_r) != (par_mode == PAR_ODD))
						rperr_nxt = 1'b1;
					rs_nxt = RSF_STOP;
				end
			end
			RSF_STOP:
			begin
				rb_nxt = rb_r + 16'd1;
				if (rb_r + 16'd1 >= bit_cyc)
				begin
					// Byte done at mid stop bit; CRC tracked two bytes behind
					rb_nxt = '0;
					rs_nxt = RSF_IDLE;
					rbyte_v = 1'b1;
					rc_nxt = rcrc_upd;
					rcp_nxt = rc_r;
					rcq_nxt = rcp_r;
					rlo_nxt = rhi_r;
					rhi_nxt = rbyte;
				end
			end
			default:
				rs_nxt = RSF_IDLE;
		endcase
	end
	// Receive registers
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rs_r <= RSF_IDLE;
			rb_r <= '0;
			rn_r <= '0;
			rsh_r <= '0;
			rc_r <= CRC_INIT;
			rcp_r <= CRC_INIT;
			rcq_r <= CRC_INIT;
			rlo_r <= '0;
			rhi_r <= '0;
			rf_r <= 2'd0;
			rq_r <= '0;
			rperr_r <= 1'b0;
			end_r <= 1'b0;
			crcok_r <= 1'b0;
		end
		else
		begin
			rs_r <= rs_nxt;
			rb_r <= rb_nxt;
			rn_r <= rn_nxt;
			rsh_r <= rsh_nxt;
			rc_r <= rc_nxt;
			rcp_r <= rcp_nxt;
			rcq_r <= rcq_nxt;
			rlo_r <= rlo_nxt;
			rhi_r <= rhi_nxt;
			rf_r <= rf_nxt;
			rq_r <= rq_nxt;
			rperr_r <= rperr_nxt;
			end_r <= end_nxt;
			crcok_r <= crcok_nxt;
		end
	end
	assign rx_end = end_r;
	assign rx_crc_ok = crcok_r;
	assign rx_par_err = rperr_r;
	// ----------------------------------------------------------------
	// Two-entry receive buffer; a full buffer drops the byte
	// ----------------------------------------------------------------
	logic [7:0] bm_r [2];
	logic [1:0] bcnt_r, bcnt_nxt;
	logic bwp_r, bwp_nxt;
	logic brp_r, brp_nxt;
	logic [7:0] bm0_nxt, bm1_nxt;
	assign buf_ready = (bcnt_r != 2'd2);
	assign rx_valid = (bcnt_r != 2'd0);
	assign rx_data = bm_r[brp_r];
	// Buffer pointer and count update
	always_comb
	begin
		bm0_nxt = bm_r[0];
		bm1_nxt = bm_r[1];
		bwp_nxt = bwp_r;
		brp_nxt = brp_r;
		bcnt_nxt = bcnt_r;
		if (rbyte_v && buf_ready)
		begin
			if (bwp_r)
				bm1_nxt = rbyte;
			else
				bm0_nxt = rbyte;
			bwp_nxt = !bwp_r;
			bcnt_nxt = bcnt_nxt + 2'd1;
		end
		if (rx_valid && rx_ready)
		begin
			brp_nxt = !brp_r;
			bcnt_nxt = bcnt_nxt - 2'd1;
		end
	end
	// Buffer registers
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			bm_r[0] <= '0;
			bm_r[1] <= '0;
			bcnt_r <= '0;
			bwp_r <= 1'b0;
			brp_r <= 1'b0;
		end
		else
		begin
			bm_r[0] <= bm0_nxt;
			bm_r[1] <= bm1_nxt;
			bcnt_r <= bcnt_nxt;
			bwp_r <= bwp_nxt;
			brp_r <= brp_nxt;
		end
	end
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_start_after_silence: assert property (@(posedge clk) disable iff (!rstn)
		$rose(oe_r) |-> $past(idle_r) >= sil_cyc)
		else $error("frame started before full silence");
	a_start_bit_low: assert property (@(posedge clk) disable iff (!rstn)
		$rose(oe_r) |-> !line_tx)
		else $error("frame did not open with a start bit");
	a_crc_init: assert property (@(posedge clk) disable iff (!rstn)
		$rose(oe_r) |=> tc_r == CRC_INIT)
		else $error("crc not seeded at frame start");
	a_buf_not_over: assert property (@(posedge clk) disable iff (!rstn)
		bcnt_r <= 2'd2)
		else $error("receive buffer overflow");
	a_idle_line_high: assert property (@(posedge clk) disable iff (!rstn)
		(ts_r == RSF_IDLE && oe_r) |-> line_tx)
		else $error("line not marking between characters");
	a_parity_bit: assert property (@(posedge clk) disable iff (!rstn)
		(ts_r == RSF_PAR) |->
		line_tx == ((par_mode == PAR_ODD) ^ (^(data7 ? {1'b0, tsh_r[6:0]} : tsh_r))))
		else $error("parity bit does not match data");
	a_addr_range: assert property (@(posedge clk) disable iff (!rstn)
		$rose(oe_r) |-> tsh_r <= ADDR_MAX)
		else $error("frame opened with an address above the legal range");
endmodule
`default_nettype wire

/* dv/rsf_slave_model.sv */
// Behavioural slave that receives, checks and answers frames on the serial pair
`default_nettype none
module rsf_slave_model
	import rsf_pkg::*;
(
	input wire logic clk,
	input wire logic [15:0] bit_cyc,
	input wire logic [1:0] par_mode,
	input wire logic data7,
	input wire logic [7:0] own_addr,
	input wire logic [1:0] err_mode,
	input wire logic line_tx,
	input wire logic line_oe,
	output logic line_rx
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Receiver, frame check and reply
	// ----------------------------------------
	logic [7:0] cap [32];
	logic [7:0] rq [$];
	logic [7:0] b;
	logic [15:0] c;
	logic pe;
	int cap_n = 0, frm_len = 0, frm_cnt = 0, bad_cnt = 0, cyc = 0, last_end = 0, sil;
	// Half-duplex pair: a released pair rests at mark through the bias network
	wire logic bus_a = line_oe ? line_tx : 1'b1;
	// Silence follows bit time and character length; 7-bit characters are 10 bits long
	assign sil = (35 * (data7 ? 10 : 11) * int'(bit_cyc) + 9) / 10;
	always @(posedge clk) cyc <= cyc + 1;
	// Reflected CRC step; a frame with its own check appended leaves zero
	function automatic logic [15:0] crc_upd(input logic [15:0] cv, input logic [7:0] d);
		cv = cv ^ {8'h00, d};
		for (int i = 0; i < 8; i++)
			cv = cv[0] ? (cv >> 1) ^ 16'ha001 : cv >> 1;
		return cv;
	endfunction
	function automatic logic par_of(input logic [7:0] d);
		return (^(data7 ? {1'b0, d[6:0]} : d)) ^ (par_mode == PAR_ODD);
	endfunction
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Samples each bit in its middle, returns at the end of the last stop bit
	task automatic rx_char(output logic [7:0] d, output logic e);
		d = 8'h00;
		e = 1'b0;
		wt(bit_cyc / 2);
		for (int i = 0; i < (data7 ? 7 : 8); i++)
		begin
			wt(bit_cyc);
			d[i] = bus_a;
		end
		if (par_mode != PAR_NONE)
		begin
			wt(bit_cyc);
			e = bus_a !== par_of(d);
		end
		for (int i = 0; i < (par_mode == PAR_NONE ? 2 : 1); i++)
		begin
			wt(bit_cyc);
			e = e | (bus_a !== 1'b1);
		end
		wt(bit_cyc / 2);
	endtask
	task automatic tx_char(input logic [7:0] d, input logic flip);
		line_rx <= 1'b0;
		wt(bit_cyc);
		for (int i = 0; i < (data7 ? 7 : 8); i++)
		begin
			line_rx <= d[i];
			wt(bit_cyc);
		end
		if (par_mode != PAR_NONE)
		begin
			line_rx <= par_of(d) ^ flip;
			wt(bit_cyc);
		end
		line_rx <= 1'b1;
		wt(par_mode == PAR_NONE ? 2 * bit_cyc : bit_cyc);
	endtask
	// Canned read data, echo for a write; err_mode spoils the check or one parity bit
	task automatic reply();
		rq.delete();
		rq.push_back(cap[0]);
		rq.push_back(cap[1]);
		if (cap[1] == CMD_READ)
		begin
			rq.push_back(cap[5] << 1);
			for (int i = 0; i < int'(cap[5]); i++)
			begin
				rq.push_back(i == 0 ? 8'h13 : 8'h00);
				rq.push_back(i == 0 ? 8'h88 : 8'h00);
			end
		end
		else
			for (int i = 2; i < 6; i++)
				rq.push_back(cap[i]);
		c = 16'hffff;
		foreach (rq[i])
			c = crc_upd(c, rq[i]);
		rq.push_back(c[7:0] ^ {7'h00, err_mode[0]});
		rq.push_back(c[15:8]);
		foreach (rq[i])
			tx_char(rq[i], err_mode[1] && i == 1);
		last_end = cyc;
	endtask
	task automatic frame_done();
		c = 16'hffff;
		for (int i = 0; i < cap_n; i++)
			c = crc_upd(c, cap[i]);
		frm_len = cap_n;
		cap_n = 0;
		frm_cnt++;
		if (c != 16'h0000 || frm_len < 4)
			bad_cnt++;
		else if (cap[0] == own_addr)
			reply();
	endtask
	initial
	begin
		line_rx = 1'b1;
		forever
		begin
			while (bus_a !== 1'b0)
				@(posedge clk);
			if (cap_n == 0 && cyc - last_end + 4 < sil)
				bad_cnt++;
			if (cap_n != 0 && cyc - last_end > sil * 3 / 7)
			begin
				bad_cnt++;
				cap_n = 0;
			end
			rx_char(b, pe);
			bad_cnt += int'(pe);
			cap[cap_n % 32] = b;
			cap_n++;
			last_end = cyc;
			while (bus_a === 1'b1 && cyc - last_end < sil)
				@(posedge clk);
			if (cyc - last_end >= sil)
				frame_done();
		end
	end
endmodule
`default_nettype wire

/* dv/rsf_master_bench.sv */
// Self-checking bench for the RTU master frame engine
`default_nettype none
module rsf_master_bench
	import rsf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Stimulus, collection and scenarios
	// ----------------------------------------
	localparam int SIL = 616; // 3.5 characters of 11 bits, 16 cycles a bit
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic tx_last = 1'b0;
	logic tx_valid = 1'b0;
	logic rx_ready = 1'b1;
	logic hold = 1'b0;
	logic data7 = 1'b0;
	logic busy;
	logic seen_ok, seen_pe, tx_ready, rx_valid, rx_end, rx_crc_ok, rx_par_err;
	logic line_rx, line_tx, line_oe;
	logic [1:0] par_mode = PAR_EVEN;
	logic [1:0] err_mode = 2'h0;
	logic [7:0] tx_data = 8'h00;
	logic [7:0] own_addr = 8'h01;
	logic [7:0] rx_data;
	logic [7:0] got [$];
	logic [7:0] rd_w [$] = '{8'h01, 8'h03, 8'h00, 8'h04, 8'h00, 8'h02, 8'h85, 8'hca};
	logic [7:0] rd_r [$] = '{8'h01, 8'h03, 8'h04, 8'h13, 8'h88, 8'h00, 8'h00, 8'h7e, 8'h9d};
	logic [7:0] wr_w [$] = '{8'h02, 8'h06, 8'h00, 8'h04, 8'h13, 8'h88, 8'hc5, 8'h6e};
	logic [7:0] bc_f [$] = '{8'h00, 8'h06, 8'h00, 8'h04, 8'h13, 8'h88};
	int error_cnt = 0;
	int comparisons = 0;
	int ends = 0;
	int tick = 0;
	always #5 clk = ~clk;
	// Both ends share one rate and character format
	rsf_master rsf_master_i (.clk(clk), .rstn(rstn), .bit_cyc(16'h0010),
		.par_mode(par_mode), .data7(data7), .tx_data(tx_data), .tx_last(tx_last),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_end(rx_end), .rx_crc_ok(rx_crc_ok),
		.rx_par_err(rx_par_err), .busy(busy), .line_rx(line_rx), .line_tx(line_tx),
		.line_oe(line_oe));
	rsf_slave_model rsf_slave_model_i (.clk(clk), .bit_cyc(16'h0010), .par_mode(par_mode),
		.data7(data7), .own_addr(own_addr), .err_mode(err_mode), .line_tx(line_tx),
		.line_oe(line_oe), .line_rx(line_rx));
	// Receiver stalls in bursts shorter than a character, or fully while hold is set
	always @(posedge clk)
	begin
		tick <= tick + 1;
		rx_ready <= !hold && !tick[5];
		if (rx_valid === 1'b1 && rx_ready === 1'b1)
			got.push_back(rx_data);
		if (rx_end === 1'b1)
		begin
			ends++;
			seen_ok = rx_crc_ok;
			seen_pe = rx_par_err;
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		if (error_cnt == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic send(input logic [7:0] f [$]);
		int k;
		foreach (f[i])
		begin
			tx_data <= f[i];
			tx_last <= (i == f.size() - 1);
			tx_valid <= 1'b1;
			k = 0;
			do
			begin
				@(posedge clk);
				k++;
			end
			while (tx_ready !== 1'b1 && k < 9000);
		end
		tx_valid <= 1'b0;
		tx_last <= 1'b0;
	endtask
	// One command and its answer; w is the expected wire content, r the delivered bytes
	task automatic xfer(input logic [7:0] f [$], input logic [7:0] w [$],
		input logic [7:0] r [$], input logic ok, input logic pe);
		int k;
		int e0;
		int n0;
		got.delete();
		e0 = ends;
		n0 = rsf_slave_model_i.frm_cnt;
		send(f);
		chk(16'(busy), 16'h0001);
		for (k = 0; k < 4000 && rsf_slave_model_i.frm_cnt == n0; k++)
			@(posedge clk);
		chk(16'(line_oe), 16'h0000);
		chk(16'(busy), 16'h0000);
		chk(16'(rsf_slave_model_i.frm_len), 16'(f.size() + 2));
		foreach (w[i])
			chk(16'(rsf_slave_model_i.cap[i]), 16'(w[i]));
		for (k = 0; k < 6000 && ends == e0; k++)
			@(posedge clk);
		hold <= 1'b0;
		for (k = 0; k < 300 && rx_valid !== 1'b0; k++)
			@(posedge clk);
		chk(16'(ends - e0), 16'(r.size() != 0));
		chk(16'(got.size()), 16'(r.size()));
		foreach (r[i])
			chk(16'(got[i]), 16'(r[i]));
		if (r.size() != 0)
		begin
			chk(16'(seen_ok), 16'(ok));
			chk(16'(seen_pe), 16'(pe));
		end
		chk(16'(rsf_slave_model_i.bad_cnt), 16'h0000);
	endtask
	task automatic t_quiet();
		int k;
		for (k = 0; k < 2000 && tx_ready !== 1'b1; k++)
			@(posedge clk);
		chk(16'(k >= SIL - 4), 16'h0001);
	endtask
	task automatic t_read();
		xfer(rd_w[0:5], rd_w, rd_r, 1'b1, 1'b0);
	endtask
	task automatic t_write();
		par_mode <= PAR_ODD;
		own_addr <= 8'h02;
		xfer(wr_w[0:5], wr_w, wr_w, 1'b1, 1'b0);
	endtask
	task automatic t_bcast();
		logic [7:0] none [$];
		par_mode <= PAR_NONE;
		xfer(bc_f, bc_f, none, 1'b1, 1'b0);
	endtask
	task automatic t_other();
		logic [7:0] none [$];
		xfer(rd_w[0:5], rd_w, none, 1'b1, 1'b0);
	endtask
	task automatic t_bad_crc();
		logic [7:0] r [$];
		r = rd_r;
		r[7] = 8'h7f;
		par_mode <= PAR_EVEN;
		own_addr <= 8'h01;
		err_mode <= 2'h1;
		xfer(rd_w[0:5], rd_w, r, 1'b0, 1'b0);
	endtask
	task automatic t_bad_par();
		par_mode <= PAR_ODD;
		err_mode <= 2'h2;
		xfer(rd_w[0:5], rd_w, rd_r, 1'b1, 1'b1);
	endtask
	// Receiver held off for the whole answer: the buffer keeps its first two bytes
	task automatic t_full();
		par_mode <= PAR_EVEN;
		err_mode <= 2'h0;
		hold <= 1'b1;
		xfer(rd_w[0:5], rd_w, rd_r[0:1], 1'b1, 1'b0);
	endtask
	// Seven-bit characters: the payload must arrive intact in the shorter format
	task automatic t_seven();
		int k;
		int n0;
		data7 <= 1'b1;
		n0 = rsf_slave_model_i.frm_cnt;
		send(rd_w[0:5]);
		for (k = 0; k < 4000 && rsf_slave_model_i.frm_cnt == n0; k++)
			@(posedge clk);
		chk(16'(rsf_slave_model_i.frm_len), 16'h0008);
		for (k = 0; k < 6; k++)
			chk(16'(rsf_slave_model_i.cap[k]), 16'(rd_w[k]));
	endtask
	initial
	begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		t_quiet();
		t_read();
		t_write();
		t_bcast();
		t_other();
		t_bad_crc();
		t_bad_par();
		t_full();
		t_seven();
		test_done();
	end
	// A hang counts as a fault and closes the run
	initial
	begin
		repeat (100000) @(posedge clk);
		error_cnt++;
		test_done();
	end
endmodule
`default_nettype wire
